//--- core/fsc_top.sv
/*
  Second fan channel segment speed control with AXI4-Lite registers.
  Assumes zone and over-limit inputs come from monitor logic on aclk.
*/
`timescale 1ns/100ps
`default_nettype none
module fsc_top
  import fsc_pkg::*;
#(
  parameter int SLOW_CYC = PWM_SLOW_CYC,
  parameter int STEP_CYC = STEP_BASE_CYC
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Monitor inputs
  input wire logic [1:0] temp_zone,
  input wire logic any_over_limit,
  // Outputs
  output logic [2:0] thermal_source_sel,
  output logic [7:0] speed_target,
  output logic [7:0] duty,
  output logic pwm_out
);
  logic [7:0] first_segment_target;
  logic [7:0] second_segment_target;
  logic [7:0] third_segment_target;
  logic [7:0] map_ctrl;
  logic [7:0] mode_ctrl;
  logic aw_full;
  logic w_full;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [1:0] zone_q;

  fsc_duty_if dif ();

  // Field views
  wire thermal_source_upper_bit = map_ctrl[MAP_SRC_HI];
  wire pwm_rate_choice = map_ctrl[MAP_PWM_RATE];
  wire overtemp_full_speed_force = map_ctrl[MAP_FORCE];
  wire table_smoothing_on = map_ctrl[MAP_SMOOTH];
  wire rise_direct_step = map_ctrl[MAP_RISE_JUMP];
  wire fall_direct_step = map_ctrl[MAP_FALL_JUMP];
  wire [1:0] thermal_source_choice = map_ctrl[1:0];
  wire [1:0] mode_bits = mode_ctrl[MODE_LSB+1:MODE_LSB];
  wire [1:0] duty_slope_choice = mode_ctrl[SLOPE_LSB+1:SLOPE_LSB];
  fsc_mode_t channel_operating_mode;
  assign channel_operating_mode = fsc_mode_t'(mode_bits);

  // Write channel
  assign s_axi_awready = ce && !aw_full && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_full && !s_axi_bvalid;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_full || aw_take;
  wire w_have = w_full || w_take;
  wire [11:0] wr_addr = aw_full ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_full ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_full ? w_strb : s_axi_wstrb;
  wire wr_go = ce && aw_have && w_have && !s_axi_bvalid;
  wire [9:0] wr_idx = wr_addr[11:2];
  wire wr_lane = wr_strb[0];
  wire wr_seg1 = wr_idx == {2'b00, IDX_SEG1};
  wire wr_seg2 = wr_idx == {2'b00, IDX_SEG2};
  wire wr_seg3 = wr_idx == {2'b00, IDX_SEG3};
  wire wr_map = wr_idx == {2'b00, IDX_MAP};
  wire wr_mode = wr_idx == {2'b00, IDX_MODE};
  wire wr_stat = wr_idx == {2'b00, IDX_STAT};
  wire wr_hit = wr_seg1 || wr_seg2 || wr_seg3 || wr_map || wr_mode || wr_stat;
  wire wr_en = wr_go && wr_lane;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_full <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_take) begin
          w_full <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_segment_target <= RST_SEG1;
      second_segment_target <= RST_SEG2;
      third_segment_target <= RST_SEG3;
      map_ctrl <= RST_MAP;
      mode_ctrl <= RST_MODE;
    end else if (ce && wr_en) begin
      if (wr_seg1) begin
        first_segment_target <= wr_data[7:0];
      end else if (wr_seg2) begin
        second_segment_target <= wr_data[7:0];
      end else if (wr_seg3) begin
        third_segment_target <= wr_data[7:0];
      end else if (wr_map) begin
        map_ctrl <= wr_data[7:0];
      end else if (wr_mode) begin
        mode_ctrl <= {4'h0, wr_data[3:0]};
      end
    end
  end

  // Read channel
  assign s_axi_arready = ce && !s_axi_rvalid;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [9:0] rd_idx = s_axi_araddr[11:2];
  wire [7:0] status_byte = {4'h0, zone_q, duty == dif.target, dif.jump};
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    if (rd_idx == {2'b00, IDX_SEG1}) begin
      rd_byte = first_segment_target;
    end else if (rd_idx == {2'b00, IDX_SEG2}) begin
      rd_byte = second_segment_target;
    end else if (rd_idx == {2'b00, IDX_SEG3}) begin
      rd_byte = third_segment_target;
    end else if (rd_idx == {2'b00, IDX_MAP}) begin
      rd_byte = map_ctrl;
    end else if (rd_idx == {2'b00, IDX_MODE}) begin
      rd_byte = mode_ctrl;
    end else if (rd_idx == {2'b00, IDX_STAT}) begin
      rd_byte = status_byte;
    end else begin
      rd_byte = 8'h00;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h0, rd_byte};
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Segment selection and duty control
  fsc_zone_t zone;
  assign zone = fsc_zone_t'(temp_zone);
  wire rise_hi = (zone == FSC_ZONE_HIGH) && (zone_q != FSC_ZONE_HIGH);
  wire fall_hi = (zone != FSC_ZONE_HIGH) && (zone_q == FSC_ZONE_HIGH);
  wire [7:0] seg_raw = (zone == FSC_ZONE_HIGH) ? first_segment_target :
                       (zone == FSC_ZONE_MID) ? second_segment_target : third_segment_target;
  wire [7:0] seg_upper = (zone == FSC_ZONE_MID) ? first_segment_target : second_segment_target;
  wire [8:0] seg_sum = {1'b0, seg_raw} + {1'b0, seg_upper};
  wire [7:0] seg_smooth = (table_smoothing_on && zone != FSC_ZONE_HIGH) ? seg_sum[8:1] : seg_raw;
  wire forced = overtemp_full_speed_force && any_over_limit;
  wire auto_mode = (channel_operating_mode == FSC_MODE_SPEED) || (channel_operating_mode == FSC_MODE_DUTY);
  wire fall_jump = fall_hi && fall_direct_step;
  wire [7:0] next_target = forced ? DUTY_FULL : fall_jump ? second_segment_target : seg_smooth;
  wire next_jump = forced || (rise_hi && rise_direct_step) || fall_jump;
  wire [17:0] step_len = SCNT_W'(STEP_CYC) << duty_slope_choice;

  assign dif.target = next_target;
  assign dif.jump = auto_mode && next_jump;
  assign dif.hold = !auto_mode;
  assign dif.step_cycles = step_len;
  assign duty = dif.duty;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zone_q <= FSC_ZONE_LOW;
      speed_target <= '0;
      thermal_source_sel <= '0;
    end else if (ce) begin
      zone_q <= temp_zone;
      speed_target <= (channel_operating_mode == FSC_MODE_SPEED) ? next_target : 8'h00;
      thermal_source_sel <= {thermal_source_upper_bit, thermal_source_choice};
    end
  end

  fsc_ramp u_ramp (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .dif(dif.ramp)
  );

  fsc_pwm #(
    .SLOW_CYC(SLOW_CYC)
  ) u_pwm (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .rate_choice(pwm_rate_choice),
    .dif(dif.pwm),
    .pwm_out(pwm_out)
  );

  // Checks
  property p_speed_mode;
    @(posedge aclk) disable iff (!aresetn)
    (ce && channel_operating_mode == FSC_MODE_SPEED) |=> speed_target == $past(next_target);
  endproperty
  a_speed_mode: assert property (p_speed_mode) else $error("speed target not taken in mode 00");

  property p_duty_mode;
    @(posedge aclk) disable iff (!aresetn)
    (ce && channel_operating_mode == FSC_MODE_DUTY && dif.jump) |=> speed_target == 8'h00 && duty == $past(next_target);
  endproperty
  a_duty_mode: assert property (p_duty_mode) else $error("duty mode target not applied");

  property p_force_full;
    @(posedge aclk) disable iff (!aresetn)
    (ce && auto_mode && overtemp_full_speed_force && any_over_limit) |=> duty == DUTY_FULL;
  endproperty
  a_force_full: assert property (p_force_full) else $error("forced full speed missing");

  property p_smooth;
    @(posedge aclk) disable iff (!aresetn)
    (table_smoothing_on && !forced && !fall_jump && zone == FSC_ZONE_MID) |-> 9'(dif.target) == seg_sum >> 1;
  endproperty
  a_smooth: assert property (p_smooth) else $error("interpolated target wrong");

  property p_rise_jump;
    @(posedge aclk) disable iff (!aresetn)
    (ce && auto_mode && !forced && rise_hi && rise_direct_step) |=> duty == $past(first_segment_target);
  endproperty
  a_rise_jump: assert property (p_rise_jump) else $error("rise jump missed segment 1");

  property p_rise_ramp;
    @(posedge aclk) disable iff (!aresetn)
    (ce && auto_mode && !forced && rise_hi && !rise_direct_step && duty < next_target) |=> duty <= $past(duty) + 8'h1;
  endproperty
  a_rise_ramp: assert property (p_rise_ramp) else $error("rise without jump stepped too far");

  property p_fall_jump;
    @(posedge aclk) disable iff (!aresetn)
    (ce && auto_mode && !forced && fall_hi && fall_direct_step) |=> duty == $past(second_segment_target);
  endproperty
  a_fall_jump: assert property (p_fall_jump) else $error("fall jump missed segment 2");

  property p_source;
    @(posedge aclk) disable iff (!aresetn)
    (ce && wr_en && wr_map) |=> ##1 thermal_source_sel == {$past(wr_data[7], 2), $past(wr_data[1:0], 2)};
  endproperty
  a_source: assert property (p_source) else $error("source select not following register");

  c_rise_jump: cover property (@(posedge aclk) disable iff (!aresetn) rise_hi && rise_direct_step);
  c_fall_ramp: cover property (@(posedge aclk) disable iff (!aresetn) fall_hi && !fall_direct_step);
  c_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

//--- core/fsc_pkg.sv
/*
  Constants for the second fan channel segment speed control block.
  Assumes a 20 MHz aclk and AXI4-Lite register access with 32-bit data.
*/
package fsc_pkg;
  // Clock and PWM timing
  localparam int CLK_HZ = 20000000;
  localparam int PWM_FAST_HZ_X10 = 235000;
  localparam int PWM_SLOW_HZ = 220;
  localparam int PWM_FAST_CYC = (CLK_HZ * 10) / PWM_FAST_HZ_X10;
  localparam int PWM_SLOW_CYC = CLK_HZ / PWM_SLOW_HZ;
  localparam int STEP_BASE_US = 1000;
  localparam int STEP_BASE_CYC = (CLK_HZ / 1000000) * STEP_BASE_US;
  localparam int PCNT_W = 17;
  localparam int SCNT_W = 18;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SEG1 = 8'hba;
  localparam logic [7:0] IDX_SEG2 = 8'hbb;
  localparam logic [7:0] IDX_SEG3 = 8'hbe;
  localparam logic [7:0] IDX_MAP = 8'hbf;
  localparam logic [7:0] IDX_MODE = 8'hc0;
  localparam logic [7:0] IDX_STAT = 8'hc1;
  // Reset values
  localparam logic [7:0] RST_SEG1 = 8'hff;
  localparam logic [7:0] RST_SEG2 = 8'hd9;
  localparam logic [7:0] RST_SEG3 = 8'h80;
  localparam logic [7:0] RST_MAP = 8'h1d;
  localparam logic [7:0] RST_MODE = 8'h01;
  // Mapping register fields
  localparam int MAP_SRC_HI = 7;
  localparam int MAP_PWM_RATE = 6;
  localparam int MAP_FORCE = 5;
  localparam int MAP_SMOOTH = 4;
  localparam int MAP_RISE_JUMP = 3;
  localparam int MAP_FALL_JUMP = 2;
  // Mode register fields
  localparam int MODE_LSB = 0;
  localparam int SLOPE_LSB = 2;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    FSC_MODE_SPEED = 2'b00,
    FSC_MODE_DUTY = 2'b01,
    FSC_MODE_MAN0 = 2'b10,
    FSC_MODE_MAN1 = 2'b11
  } fsc_mode_t;
  typedef enum logic [1:0] {
    FSC_ZONE_HIGH = 2'b00,
    FSC_ZONE_MID = 2'b01,
    FSC_ZONE_LOW = 2'b10,
    FSC_ZONE_RSV = 2'b11
  } fsc_zone_t;
endpackage

//--- core/fsc_duty_if.sv
/*
  Carrier between the controller, the duty ramp and the PWM generator.
  Assumes all users sit on aclk.
*/
`timescale 1ns/100ps
`default_nettype none
interface fsc_duty_if;
  logic [7:0] target;
  logic jump;
  logic hold;
  logic [17:0] step_cycles;
  logic [7:0] duty;
  modport ctrl (output target, output jump, output hold, output step_cycles, input duty);
  modport ramp (input target, input jump, input hold, input step_cycles, output duty);
  modport pwm (input duty);
endinterface
`default_nettype wire

//--- core/fsc_ramp.sv
/*
  Duty ramp: jumps to the target on request, otherwise steps one unit
  per interval unless held. Assumes the controller holds target and interval stable.
*/
`timescale 1ns/100ps
`default_nettype none
module fsc_ramp
  import fsc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Duty carrier
  fsc_duty_if.ramp dif
);
  logic [17:0] cnt;
  logic [7:0] duty;
  wire tick = (cnt + 18'h1 >= dif.step_cycles);
  wire need_up = (duty < dif.target);
  wire need_dn = (duty > dif.target);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
      duty <= '0;
    end else if (ce) begin
      if (dif.jump) begin
        duty <= dif.target;
        cnt <= '0;
      end else if (dif.hold || !(need_up || need_dn)) begin
        cnt <= '0;
      end else if (tick) begin
        cnt <= '0;
        duty <= need_up ? duty + 8'h1 : duty - 8'h1;
      end else begin
        cnt <= cnt + 18'h1;
      end
    end
  end
  assign dif.duty = duty;

  property p_step_one;
    @(posedge aclk) disable iff (!aresetn)
    ($changed(duty) && !$past(dif.jump)) |-> (duty == $past(duty) + 8'h1 || duty == $past(duty) - 8'h1);
  endproperty
  a_step_one: assert property (p_step_one) else $error("ramp moved by more than one unit");
endmodule
`default_nettype wire

//--- core/fsc_pwm.sv
/*
  PWM generator with two selectable output frequencies.
  Assumes duty from the ramp on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module fsc_pwm
  import fsc_pkg::*;
#(
  parameter int SLOW_CYC = PWM_SLOW_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Control
  input wire logic rate_choice,
  fsc_duty_if.pwm dif,
  // Pin
  output logic pwm_out
);
  logic [PCNT_W-1:0] cnt;
  wire [PCNT_W-1:0] period = rate_choice ? PCNT_W'(SLOW_CYC) : PCNT_W'(PWM_FAST_CYC);
  wire [PCNT_W+7:0] prod = {8'h0, period} * {{PCNT_W{1'b0}}, dif.duty};
  wire [PCNT_W-1:0] thresh = prod[PCNT_W+7:8];
  wire wrap = (cnt + PCNT_W'(1) >= period);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
      pwm_out <= 1'b0;
    end else if (ce) begin
      cnt <= wrap ? '0 : cnt + PCNT_W'(1);
      pwm_out <= (dif.duty == DUTY_FULL) || (cnt < thresh);
    end
  end

  property p_fast_bound;
    @(posedge aclk) disable iff (!aresetn)
    (!rate_choice && $stable(rate_choice)) |-> cnt < PCNT_W'(PWM_FAST_CYC);
  endproperty
  a_fast_bound: assert property (p_fast_bound) else $error("fast period exceeded");
endmodule
`default_nettype wire

//--- testbench/fsc_fan_model.sv
/*
  Fan model: takes the PWM drive and measures its period in clock cycles.
  Assumes the PWM pin is sampled on aclk.
*/
`timescale 1ns/100ps
`default_nettype none
module fsc_fan_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Drive from the block
  input wire logic pwm_in,
  // Measurement
  output var int period
);
  int cnt;
  logic last;
  // Cycles between rising edges of the drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      last <= 1'b0;
      period <= 0;
    end else begin
      last <= pwm_in;
      cnt <= cnt + 1;
      if (pwm_in && !last) begin
        period <= cnt;
        cnt <= 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb.sv
/*
  Self-checking bench for the fan segment speed block.
  Assumes a 20 MHz clock and short ramp and slow PWM counts.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb;
  import fsc_pkg::*;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, any_over_limit;
  logic awready, wready, bvalid, arready, rvalid, pwm_out;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, temp_zone, r;
  logic [2:0] sel;
  logic [7:0] speed_target, duty, s2, s3;
  int period, fails, checked, cyc;
  int regs[int];
  fsc_top #(.SLOW_CYC(64), .STEP_CYC(4)) uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .temp_zone(temp_zone), .any_over_limit(any_over_limit), .thermal_source_sel(sel),
    .speed_target(speed_target), .duty(duty), .pwm_out(pwm_out));
  fsc_fan_model fan (.aclk(aclk), .aresetn(aresetn), .pwm_in(pwm_out), .period(period));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i);
    axi_read(12'({i, 2'b00}), d, r);
    `CHK("rresp", RESP_OKAY, r)
    `CHK("reg", 32'(regs[i]), d)
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    axi_write(12'({i, 2'b00}), {24'h0, v}, r);
    `CHK("bresp", RESP_OKAY, r)
    regs[i] = v;
    rd(i);
  endtask
  task automatic set_map(input logic [7:0] v);
    v = v | 8'($urandom & 32'h83);
    wr(IDX_MAP, v);
    repeat (2) @(posedge aclk);
    `CHK("sel", {v[7], v[1:0]}, sel)
  endtask
  task automatic wait_duty(input logic [7:0] v, input int lim);
    int n;
    n = 0;
    while (duty !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
    `CHK("duty", v, duty)
  endtask
  task automatic step_gap(input int e);
    int n;
    logic [7:0] p;
    for (int k = 0; k < 2; k++) begin
      p = duty;
      n = 0;
      while (duty === p && n < 100) begin
        @(posedge aclk);
        n++;
      end
    end
    `CHK("step_cycles", e, n)
    `CHK("step_size", p + 8'h01, duty)
  endtask
  initial begin
    aresetn = 1'b0; ce = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 12'h0; araddr = 12'h0; wdata = 32'h0;
    wstrb = 4'h0; temp_zone = 2'b10; any_over_limit = 1'b0; fails = 0; checked = 0; cyc = 0;
    void'($urandom(32'h5f395b0b));
    regs[IDX_SEG1] = 'hff; regs[IDX_SEG2] = 'hd9; regs[IDX_SEG3] = 'h80;
    regs[IDX_MAP] = 'h1d; regs[IDX_MODE] = 'h01;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Ramp from zero, slope 0 then 1
    step_gap(4);
    wr(IDX_MODE, 8'h05);
    step_gap(8);
    wr(IDX_MODE, 8'h01);
    // Reset values and unmapped place
    foreach (regs[i]) rd(8'(i));
    `CHK("sel_rst", 3'b001, sel)
    axi_read(12'h000, d, r);
    `CHK("unmapped_rresp", RESP_SLVERR, r)
    `CHK("unmapped_rdata", 32'h0, d)
    axi_write(12'h004, 32'hff, r);
    `CHK("unmapped_bresp", RESP_SLVERR, r)
    wait_duty(8'((regs[IDX_SEG3] + regs[IDX_SEG2]) / 2), 800);
    // New targets, smoothing off, both jumps on
    s2 = 8'h40 + 8'($urandom % 128);
    s3 = 8'($urandom);
    wr(IDX_SEG2, s2);
    wr(IDX_SEG3, s3);
    set_map(8'h0c);
    temp_zone <= 2'b00;
    wait_duty(8'(regs[IDX_SEG1]), 4);
    temp_zone <= 2'b01;
    wait_duty(s2, 4);
    // PWM period at both rates
    repeat (2600) @(posedge aclk);
    `CHK("period_fast", PWM_FAST_CYC, period)
    set_map(8'h4c);
    repeat (1100) @(posedge aclk);
    `CHK("period_slow", 64, period)
    // Over-limit force
    any_over_limit <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK("no_force", s2, duty)
    set_map(8'h2c);
    wait_duty(DUTY_FULL, 6);
    any_over_limit <= 1'b0;
    set_map(8'h0c);
    temp_zone <= 2'b00;
    repeat (3) @(posedge aclk);
    temp_zone <= 2'b01;
    wait_duty(s2, 4);
    // Rise with ramp, then fall with ramp
    set_map(8'h04);
    temp_zone <= 2'b00;
    repeat (4) @(posedge aclk);
    `CHK("rise_ramp", 1'b1, duty >= s2 && duty <= s2 + 8'h01)
    set_map(8'h08);
    temp_zone <= 2'b01;
    repeat (3) @(posedge aclk);
    temp_zone <= 2'b00;
    repeat (3) @(posedge aclk);
    temp_zone <= 2'b01;
    repeat (4) @(posedge aclk);
    `CHK("fall_ramp", 1'b1, duty >= 8'hfe)
    // Clock enable low freezes the ramp
    ce <= 1'b0;
    repeat (8) @(posedge aclk);
    `CHK("ce_freeze", 8'hfe, duty)
    ce <= 1'b1;
    // Manual mode holds duty; status shows zone 01, no jump, off target
    wr(IDX_MODE, 8'h02);
    s3 = duty;
    repeat (8) @(posedge aclk);
    `CHK("hold_mode", s3, duty)
    axi_read(12'({IDX_STAT, 2'b00}), d, r);
    `CHK("status_rresp", RESP_OKAY, r)
    `CHK("status", 32'h4, d)
    wr(IDX_MODE, 8'h01);
    // Mode 00 exposes the speed target
    set_map(8'h0c);
    wr(IDX_MODE, 8'h00);
    repeat (3) @(posedge aclk);
    `CHK("speed_seg2", s2, speed_target)
    set_map(8'h1c);
    repeat (3) @(posedge aclk);
    `CHK("speed_smooth", 8'((32'(s2) + regs[IDX_SEG1]) / 2), speed_target)
    // Fall jump lands on segment 2 even with smoothing on
    temp_zone <= 2'b00;
    repeat (3) @(posedge aclk);
    temp_zone <= 2'b01;
    repeat (2) @(posedge aclk);
    `CHK("fall_jump_smooth", s2, duty)
    wr(IDX_MODE, 8'h01);
    repeat (3) @(posedge aclk);
    `CHK("speed_duty_mode", 8'h00, speed_target)
    stop_test();
  end
endmodule
`default_nettype wire
